// ### hw/tmcc_top.sv
// Three-channel 16-bit timer: pin compare/capture control and interrupt enables.
// Assumes an APB master on mclk and pins synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Compare mode: level bit sets the pin's initial level unless output disabled.
// - Compare mode: low bits pick disabled, low, high or toggle on match.
// - Channel 2 B field top bit makes B register capture from its pin.
// - Capture mode: low bits pick rising, falling or both edges.
// - Channel 0 A register uses the same encoding with its own pin, but capture with the level bit set captures nothing.
// - Each of the three channels has its own interrupt enable register.
// - Channel 0: enable bit 7 gates the converter start request from A register events.
// - Enable bit 6 always reads one and ignores writes.
// - Channels 1 and 2: bit 5 gates the underflow interrupt from its flag.
// - Channel 0: enable bit 5 is reserved, no underflow function.
// - Bit 4 gates the overflow interrupt raised while the overflow flag is set.
// - Bit 3 is writable on channel 0 but gates no interrupt; reserved zero elsewhere.
// - Clearing at overflow or underflow wins and sets no flag.
module tmcc_top
  import tmcc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chan0_pin_a_i,
  output logic             chan0_pin_a_o,
  output logic             chan0_pin_a_oe,
  input  wire logic        chan2_pin_b_i,
  output logic             chan2_pin_b_o,
  output logic             chan2_pin_b_oe,
  output logic             adc_start_req,
  output logic      [2:0]  overflow_irq,
  output logic      [2:0]  underflow_irq,
  output logic             irq
);
`include "tmcc_params.svh"

  tmcc_top_st_t s_q;
  tmcc_top_st_t s_d;
  logic         setup;
  logic         acc_wr;
  logic         hit;
  logic [31:0]  rd_val;
  logic [7:0]   set;
  logic [7:0]   gate;
  logic [7:0]   wmask;
  logic [2:0]   run;
  logic [2:0]   down;
  logic [2:0]   clr;

  tmcc_cc_if cc0 ();
  tmcc_cc_if cc2 ();

  // ****************************************
  // Compare/capture units
  // ****************************************
  // The channel 0 field forbids capture with the level bit set.
  tmcc_cc_unit #(.CAP_INIT_LEGAL(1'b0)) u_cc0
  (
    .mclk  (mclk),
    .rst_b (rst_b),
    .cc    (cc0.unit)
  );

  tmcc_cc_unit #(.CAP_INIT_LEGAL(1'b1)) u_cc2
  (
    .mclk  (mclk),
    .rst_b (rst_b),
    .cc    (cc2.unit)
  );

  assign setup  = psel & ~penable;
  assign acc_wr = psel & penable & pwrite;

  assign cc0.io       = s_q.io0[3:0];
  assign cc0.io_ld    = s_q.io0_ld;
  assign cc0.cnt_en   = s_q.ctrl[0];
  assign cc0.cnt      = s_q.cnt[0];
  assign cc0.gr_wr    = acc_wr && paddr == `TMCC_OFF_GRA0;
  assign cc0.gr_wdata = pwdata[15:0];
  assign cc0.pin_i    = chan0_pin_a_i;

  assign cc2.io       = s_q.io2[7:4];
  assign cc2.io_ld    = s_q.io2_ld;
  assign cc2.cnt_en   = s_q.ctrl[2];
  assign cc2.cnt      = s_q.cnt[2];
  assign cc2.gr_wr    = acc_wr && paddr == `TMCC_OFF_GRB2;
  assign cc2.gr_wdata = pwdata[15:0];
  assign cc2.pin_i    = chan2_pin_b_i;

  // ****************************************
  // Register read decode
  // ****************************************
  always_comb
  begin
    hit    = 1'b1;
    rd_val = '0;
    unique case (paddr)
      `TMCC_OFF_CTRL:  rd_val[7:0]  = s_q.ctrl;
      `TMCC_OFF_IO0:   rd_val[7:0]  = s_q.io0;
      `TMCC_OFF_IO2:   rd_val[7:0]  = s_q.io2;
      `TMCC_OFF_TIER0: rd_val[7:0]  = s_q.timer_irq_enable[0];
      `TMCC_OFF_TIER1: rd_val[7:0]  = s_q.timer_irq_enable[1];
      `TMCC_OFF_TIER2: rd_val[7:0]  = s_q.timer_irq_enable[2];
      `TMCC_OFF_STAT:  rd_val[7:0]  = s_q.stat;
      `TMCC_OFF_MASK:  rd_val[7:0]  = s_q.mask;
      `TMCC_OFF_CNT0:  rd_val[15:0] = s_q.cnt[0];
      `TMCC_OFF_CNT1:  rd_val[15:0] = s_q.cnt[1];
      `TMCC_OFF_CNT2:  rd_val[15:0] = s_q.cnt[2];
      `TMCC_OFF_GRA0:  rd_val[15:0] = cc0.gr;
      `TMCC_OFF_GRB2:  rd_val[15:0] = cc2.gr;
      default:         hit = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d        = s_q;
    set        = '0;
    wmask      = '0;
    s_d.io0_ld = 1'b0;
    s_d.io2_ld = 1'b0;
    s_d.adc    = s_q.timer_irq_enable[0][`TMCC_TIMER_IRQ_ENABLE_ADC] & (cc0.match | cc0.capture);
    set[`TMCC_ST_EVA0] = cc0.match | cc0.capture;
    set[`TMCC_ST_EVB2] = cc2.match | cc2.capture;

    run  = s_q.ctrl[2:0];
    down = {s_q.ctrl[`TMCC_CTRL_DOWN + 2], s_q.ctrl[`TMCC_CTRL_DOWN + 1], 1'b0};
    clr  = {s_q.ctrl[`TMCC_CTRL_CLR2] & cc2.match, 1'b0, s_q.ctrl[`TMCC_CTRL_CLR0] & cc0.match};
    for (int i = 0; i < 3; i++)
    begin
      if (run[i])
      begin
        if (clr[i])
          s_d.cnt[i] = '0;
        else if (down[i])
          s_d.cnt[i] = s_q.cnt[i] - 16'h0001;
        else
          s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
        // A clear in the same cycle suppresses both flags.
        if (!clr[i] && !down[i] && s_q.cnt[i] == `TMCC_CNT_MAX)
          set[`TMCC_ST_OV + i] = 1'b1;
        if (!clr[i] && down[i] && s_q.cnt[i] == 16'h0000)
          set[`TMCC_ST_UN + i] = 1'b1;
      end
    end

    if (acc_wr)
    begin
      unique case (paddr)
        `TMCC_OFF_CTRL:  s_d.ctrl = pwdata[7:0];
        `TMCC_OFF_IO0:
        begin
          s_d.io0    = pwdata[7:0];
          s_d.io0_ld = 1'b1;
        end
        `TMCC_OFF_IO2:
        begin
          s_d.io2    = pwdata[7:0];
          s_d.io2_ld = 1'b1;
        end
        `TMCC_OFF_TIER0: wmask = `TMCC_TIER0_WMASK;
        `TMCC_OFF_TIER1: wmask = `TMCC_TIER12_WMASK;
        `TMCC_OFF_TIER2: wmask = `TMCC_TIER12_WMASK;
        `TMCC_OFF_MASK:  s_d.mask = pwdata[7:0];
        `TMCC_OFF_CNT0:  s_d.cnt[0] = pwdata[15:0];
        `TMCC_OFF_CNT1:  s_d.cnt[1] = pwdata[15:0];
        `TMCC_OFF_CNT2:  s_d.cnt[2] = pwdata[15:0];
        default:         s_d.ctrl = s_q.ctrl;
      endcase
      // One enable register per channel, each with its own reserved bits.
      for (int i = 0; i < 3; i++)
      begin
        if (paddr == 8'(`TMCC_OFF_TIER0 + 4 * i))
          s_d.timer_irq_enable[i] = (pwdata[7:0] & wmask) | `TMCC_TIMER_IRQ_ENABLE_RST;
      end
    end

    // Hardware set wins over a write-one clear in the same cycle.
    if (acc_wr && paddr == `TMCC_OFF_STAT)
      s_d.stat = (s_q.stat & ~pwdata[7:0]) | set;
    else
      s_d.stat = s_q.stat | set;

    if (setup)
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q      <= '0;
      s_q.timer_irq_enable <= {3{`TMCC_TIMER_IRQ_ENABLE_RST}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs and interrupt
  // ****************************************
  assign prdata         = s_q.prdata;
  assign pready         = 1'b1;
  assign pslverr        = psel & penable & ~hit;
  assign chan0_pin_a_o  = cc0.pin_o;
  assign chan0_pin_a_oe = cc0.pin_oe;
  assign chan2_pin_b_o  = cc2.pin_o;
  assign chan2_pin_b_oe = cc2.pin_oe;
  assign adc_start_req  = s_q.adc;

  always_comb
  begin
    gate = 8'h03;
    for (int i = 0; i < 3; i++)
    begin
      overflow_irq[i]      = s_q.stat[`TMCC_ST_OV + i] & s_q.timer_irq_enable[i][`TMCC_TIMER_IRQ_ENABLE_OV];
      gate[`TMCC_ST_OV + i] = s_q.timer_irq_enable[i][`TMCC_TIMER_IRQ_ENABLE_OV];
    end
    underflow_irq[0] = 1'b0;
    for (int i = 1; i < 3; i++)
    begin
      underflow_irq[i]      = s_q.stat[`TMCC_ST_UN + i] & s_q.timer_irq_enable[i][`TMCC_TIMER_IRQ_ENABLE_UN];
      gate[`TMCC_ST_UN + i] = s_q.timer_irq_enable[i][`TMCC_TIMER_IRQ_ENABLE_UN];
    end
  end

  assign irq = |(s_q.stat & s_q.mask & gate);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_timer_irq_enable_rsv_one: assert property (
    setup && !pwrite && (paddr == `TMCC_OFF_TIER0 || paddr == `TMCC_OFF_TIER2)
    |=> prdata[`TMCC_TIMER_IRQ_ENABLE_RSV])
    else $error("reserved enable bit 6 did not read as one");

  a_timer_irq_enable_d_rsv: assert property (
    acc_wr && paddr == `TMCC_OFF_TIER1 |=> !s_q.timer_irq_enable[1][`TMCC_TIMER_IRQ_ENABLE_D])
    else $error("channel 1 bit 3 took a write");

  a_tier0_un_rsv: assert property (
    acc_wr && paddr == `TMCC_OFF_TIER0 |=> !s_q.timer_irq_enable[0][`TMCC_TIMER_IRQ_ENABLE_UN])
    else $error("channel 0 bit 5 took a write");

  a_ov_flag_set: assert property (
    s_q.ctrl[1] && !s_q.ctrl[`TMCC_CTRL_DOWN + 1] && s_q.cnt[1] == `TMCC_CNT_MAX
    |=> s_q.stat[`TMCC_ST_OV + 1] && overflow_irq[1] == s_q.timer_irq_enable[1][`TMCC_TIMER_IRQ_ENABLE_OV])
    else $error("overflow flag or request missing on channel 1");

  a_un_flag_set: assert property (
    s_q.ctrl[2] && s_q.ctrl[`TMCC_CTRL_DOWN + 2] && s_q.cnt[2] == 16'h0000 && !clr[2]
    |=> s_q.stat[`TMCC_ST_UN + 2] && underflow_irq[2] == s_q.timer_irq_enable[2][`TMCC_TIMER_IRQ_ENABLE_UN])
    else $error("underflow flag or request missing on channel 2");

  a_clear_wins: assert property (
    clr[0] && s_q.ctrl[0] && s_q.cnt[0] == `TMCC_CNT_MAX && !acc_wr
    |=> s_q.cnt[0] == 16'h0000 && !$rose(s_q.stat[`TMCC_ST_OV]))
    else $error("overflow flagged although clearing coincided");

  a_match_high: assert property (
    s_q.io0[3:0] == 4'b0010 && cc0.match && !s_q.io0_ld
    |=> chan0_pin_a_o && chan0_pin_a_oe)
    else $error("pin not driven high after match");

  a_init_level: assert property (
    s_q.io2_ld && !s_q.io2[7] && s_q.io2[5:4] != 2'b00
    |=> chan2_pin_b_o == $past(s_q.io2[6]) && chan2_pin_b_oe)
    else $error("initial pin level not applied");

  a_capture_load: assert property (
    cc2.capture |=> cc2.gr == $past(s_q.cnt[2]))
    else $error("capture did not load the counter");

  a_ch0_rising: assert property (
    s_q.io0[3:0] == 4'b1000 && chan0_pin_a_i && !$past(chan0_pin_a_i) |-> cc0.capture)
    else $error("channel 0 missed a rising edge");

  a_adc_gate: assert property (
    (cc0.match || cc0.capture) ##1 adc_start_req |-> $past(s_q.timer_irq_enable[0][`TMCC_TIMER_IRQ_ENABLE_ADC]))
    else $error("start request issued while disabled");

  a_match_equal: assert property (
    cc0.match |-> s_q.cnt[0] == cc0.gr && s_q.ctrl[0])
    else $error("match without equality");

  a_oe_off: assert property (
    !s_q.io0[3] && s_q.io0[1:0] == 2'b00 |-> !chan0_pin_a_oe)
    else $error("channel 0 pin driven with output disabled");

  a_cap_no_drive: assert property (
    s_q.io2[7] |-> !chan2_pin_b_oe)
    else $error("channel 2 pin driven in capture mode");

  a_ch0_prohib: assert property (
    s_q.io0[3:2] == 2'b11 |-> !cc0.capture && !chan0_pin_a_oe)
    else $error("prohibited channel 0 code captured or drove the pin");

  a_adc_source: assert property (
    adc_start_req |-> $past(cc0.match) || $past(cc0.capture))
    else $error("start request without an A register event");

  a_init_level_a: assert property (
    s_q.io0_ld && !s_q.io0[3] |=> chan0_pin_a_o == $past(s_q.io0[2]))
    else $error("channel 0 initial level not applied");

  a_tier1_rsv_hold: assert property (
    acc_wr && paddr == `TMCC_OFF_TIER1 |=> s_q.timer_irq_enable[1][`TMCC_TIMER_IRQ_ENABLE_RSV])
    else $error("channel 1 bit 6 lost its one");

  a_un_ch1_set: assert property (
    s_q.ctrl[1] && s_q.ctrl[`TMCC_CTRL_DOWN + 1] && s_q.cnt[1] == 16'h0000
    |=> s_q.stat[`TMCC_ST_UN + 1])
    else $error("underflow flag missing on channel 1");

  a_irq_ov_level: assert property (
    s_q.stat[`TMCC_ST_OV] && s_q.timer_irq_enable[0][`TMCC_TIMER_IRQ_ENABLE_OV] && s_q.mask[`TMCC_ST_OV] |-> irq)
    else $error("enabled overflow did not raise the interrupt");

  a_timer_irq_enable_d_keep: assert property (
    acc_wr && paddr == `TMCC_OFF_TIER0
    |=> s_q.timer_irq_enable[0][`TMCC_TIMER_IRQ_ENABLE_D] == $past(pwdata[`TMCC_TIMER_IRQ_ENABLE_D]))
    else $error("channel 0 bit 3 did not take the write");

  a_event_sticky: assert property (
    cc2.match || cc2.capture |=> s_q.stat[`TMCC_ST_EVB2])
    else $error("channel 2 event not flagged");

endmodule
`default_nettype wire

// ### hw/tmcc_params.svh
// Offsets, field positions and reset values of the timer capture/compare block.
// Assumes a 32-bit APB slave with an 8-bit byte address.
`ifndef TMCC_PARAMS_SVH
`define TMCC_PARAMS_SVH

`define TMCC_OFF_CTRL      8'h00
`define TMCC_OFF_IO0       8'h04
`define TMCC_OFF_IO2       8'h08
`define TMCC_OFF_TIER0     8'h0c
`define TMCC_OFF_TIER1     8'h10
`define TMCC_OFF_TIER2     8'h14
`define TMCC_OFF_STAT      8'h18
`define TMCC_OFF_MASK      8'h1c
`define TMCC_OFF_CNT0      8'h20
`define TMCC_OFF_CNT1      8'h24
`define TMCC_OFF_CNT2      8'h28
`define TMCC_OFF_GRA0      8'h2c
`define TMCC_OFF_GRB2      8'h30

`define TMCC_IO_CAP        3
`define TMCC_IO_INIT       2
`define TMCC_TIMER_IRQ_ENABLE_ADC      7
`define TMCC_TIMER_IRQ_ENABLE_RSV      6
`define TMCC_TIMER_IRQ_ENABLE_UN       5
`define TMCC_TIMER_IRQ_ENABLE_OV       4
`define TMCC_TIMER_IRQ_ENABLE_D        3
`define TMCC_TIMER_IRQ_ENABLE_RST      8'h40
`define TMCC_TIER0_WMASK   8'h98
`define TMCC_TIER12_WMASK  8'hb0

`define TMCC_CTRL_DOWN     3
`define TMCC_CTRL_CLR0     6
`define TMCC_CTRL_CLR2     7
`define TMCC_ST_EVA0       0
`define TMCC_ST_EVB2       1
`define TMCC_ST_OV         2
`define TMCC_ST_UN         4
`define TMCC_CNT_MAX       16'hffff

`endif

// ### hw/tmcc_pkg.sv
// Types shared by the timer capture/compare block.
// Assumes tmcc_params.svh for all numeric constants.
package tmcc_pkg;

  typedef enum logic [1:0] {TMCC_ACT_OFF, TMCC_ACT_LOW, TMCC_ACT_HIGH, TMCC_ACT_TOGGLE} tmcc_act_t;

  typedef struct packed {
    logic [7:0]       ctrl;
    logic [7:0]       io0;
    logic [7:0]       io2;
    logic [2:0][7:0]  timer_irq_enable;
    logic [2:0][15:0] cnt;
    logic [7:0]       stat;
    logic [7:0]       mask;
    logic [31:0]      prdata;
    logic             io0_ld;
    logic             io2_ld;
    logic             adc;
  } tmcc_top_st_t;

  typedef struct packed {
    logic [15:0] gr;
    logic        lvl;
    logic        pin_prev;
  } tmcc_unit_st_t;

endpackage

// ### hw/tmcc_cc_if.sv
// Signals between the timer top and one compare/capture unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tmcc_cc_if;
  logic [3:0]  io;
  logic        io_ld;
  logic        cnt_en;
  logic [15:0] cnt;
  logic        gr_wr;
  logic [15:0] gr_wdata;
  logic        pin_i;
  logic [15:0] gr;
  logic        match;
  logic        capture;
  logic        pin_o;
  logic        pin_oe;
  modport unit (input io, io_ld, cnt_en, cnt, gr_wr, gr_wdata, pin_i,
                output gr, match, capture, pin_o, pin_oe);
  modport ctrl (output io, io_ld, cnt_en, cnt, gr_wr, gr_wdata, pin_i,
                input gr, match, capture, pin_o, pin_oe);
endinterface
`default_nettype wire

// ### hw/tmcc_cc_unit.sv
// One general register with its pin: output compare or input capture.
// Assumes the pin input is synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module tmcc_cc_unit
  import tmcc_pkg::*;
#(
  parameter bit CAP_INIT_LEGAL = 1'b1
)
(
  input wire logic mclk,
  input wire logic rst_b,
  tmcc_cc_if.unit  cc
);
`include "tmcc_params.svh"

  tmcc_unit_st_t s_q;
  tmcc_unit_st_t s_d;
  logic          cap_mode;
  logic          edge_hit;

  // ****************************************
  // Compare and capture
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.pin_prev = cc.pin_i;
    cap_mode = cc.io[`TMCC_IO_CAP];
    unique case (cc.io[1:0])
      2'b00:   edge_hit = cc.pin_i & ~s_q.pin_prev;
      2'b01:   edge_hit = ~cc.pin_i & s_q.pin_prev;
      default: edge_hit = cc.pin_i ^ s_q.pin_prev;
    endcase
    // Some units forbid the capture code with the level bit set; it captures nothing.
    cc.capture = cap_mode & (CAP_INIT_LEGAL | ~cc.io[`TMCC_IO_INIT]) & edge_hit;
    // Gated by the run bit so a stopped counter does not match every cycle.
    cc.match = ~cap_mode & cc.cnt_en & (cc.cnt == s_q.gr);
    if (cc.capture)
      s_d.gr = cc.cnt;
    else if (cc.gr_wr)
      s_d.gr = cc.gr_wdata;
    if (cc.io_ld)
      s_d.lvl = cc.io[`TMCC_IO_INIT];
    else if (cc.match)
    begin
      unique case (tmcc_act_t'(cc.io[1:0]))
        TMCC_ACT_OFF:    s_d.lvl = s_q.lvl;
        TMCC_ACT_LOW:    s_d.lvl = 1'b0;
        TMCC_ACT_HIGH:   s_d.lvl = 1'b1;
        TMCC_ACT_TOGGLE: s_d.lvl = ~s_q.lvl;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign cc.gr     = s_q.gr;
  assign cc.pin_o  = s_q.lvl;
  assign cc.pin_oe = ~cc.io[`TMCC_IO_CAP] & (cc.io[1:0] != 2'b00);

  a_edge_falling: assert property (@(posedge mclk) disable iff (!rst_b)
    cc.capture && cc.io[1:0] == 2'b01 |-> !cc.pin_i && s_q.pin_prev)
    else $error("capture on falling edge without a falling edge");

endmodule
`default_nettype wire

// ### test/tmcc_pin_model.sv
// External party on one timer pin of the capture/compare block.
// Assumes each pin is split into input, output and output enable.
`timescale 1ns/1ps
`default_nettype none
module tmcc_pin_model
(
  input  wire logic mclk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_i
);
  logic lvl = 1'b0;

  // The wire shows the device's level while it drives, else ours.
  assign pin_i = pin_oe ? pin_o : lvl;

  task automatic set_lvl(input logic v);
    @(posedge mclk);
    lvl <= v;
  endtask
endmodule
`default_nettype wire

// ### test/tb_timer_io_capture_compare.sv
// Self-checking bench for the timer capture/compare block.
// Assumes an APB slave on mclk and pins synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
`include "tmcc_params.svh"
module tb_timer_io_capture_compare;
  logic        mclk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        a_i;
  logic        a_o;
  logic        a_oe;
  logic        b_i;
  logic        b_o;
  logic        b_oe;
  logic        adc;
  logic        irq;
  logic [2:0]  ovf;
  logic [2:0]  unf;
  logic [31:0] rd;
  logic        err;
  int          n_errors;
  int          n_compared;
  int          cyc;
  int          n;

  tmcc_top DUT (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chan0_pin_a_i(a_i), .chan0_pin_a_o(a_o), .chan0_pin_a_oe(a_oe),
    .chan2_pin_b_i(b_i), .chan2_pin_b_o(b_o), .chan2_pin_b_oe(b_oe),
    .adc_start_req(adc), .overflow_irq(ovf), .underflow_irq(unf), .irq);
  tmcc_pin_model pm0 (.mclk, .pin_o(a_o), .pin_oe(a_oe), .pin_i(a_i));
  tmcc_pin_model pm2 (.mclk, .pin_o(b_o), .pin_oe(b_oe), .pin_i(b_i));

  // ****************************************
  // Clock, timeout and checking tasks
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Waits end half a cycle after an edge, where registered outputs have settled.
  task automatic wt(input int c);
    repeat (c) @(negedge mclk);
  endtask

  // Read data and the error flag are taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Checks after a write look half a cycle later, once the outputs have settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(negedge mclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    rdc(`TMCC_OFF_TIER0, 32'hff, 32'h40);
    rdc(`TMCC_OFF_TIER2, 32'hff, 32'h40);
    wr(`TMCC_OFF_TIER0, 32'hff);
    rdc(`TMCC_OFF_TIER0, 32'hff, 32'hd8);
    wr(`TMCC_OFF_TIER1, 32'hff);
    rdc(`TMCC_OFF_TIER1, 32'hff, 32'hf0);
    apb(1'b0, 8'hfc, 32'h0);
    chk1(err, 1'b1);
    chk(rd, 32'h0);

    wr(`TMCC_OFF_GRA0, 32'h5);
    for (int i = 0; i < 8; i++)
    begin
      wr(`TMCC_OFF_CTRL, 32'h0);
      wr(`TMCC_OFF_CNT0, 32'h0);
      wr(`TMCC_OFF_IO0, i);
      wt(3);
      chk1(a_oe, i[1:0] != 2'd0);
      if (i[1:0] != 2'd0)
        chk1(a_o, i[2]);
      wr(`TMCC_OFF_CTRL, 32'h1);
      n = 0;
      do
      begin
        @(negedge mclk);
        n++;
      end
      while (adc !== 1'b1 && n < 50);
      chk1(adc, 1'b1);
      if (i[1:0] != 2'd0)
        chk1(a_o, i[1:0] == 2'd3 ? !i[2] : i[1]);
    end
    // With the converter trigger disabled a match must stay silent.
    wr(`TMCC_OFF_CTRL, 32'h0);
    wr(`TMCC_OFF_CNT0, 32'h0);
    wr(`TMCC_OFF_TIER0, 32'h0);
    wr(`TMCC_OFF_CTRL, 32'h1);
    n = 0;
    repeat (20) @(negedge mclk) n += (adc === 1'b1);
    chk(n, 0);
    rdc(`TMCC_OFF_TIER0, 32'hff, 32'h40);

    wr(`TMCC_OFF_CTRL, 32'h0);
    // Channel 0 capture, then the prohibited code, which must capture nothing.
    wr(`TMCC_OFF_IO0, 32'h08);
    wr(`TMCC_OFF_CNT0, 32'h0abc);
    pm0.set_lvl(1'b1);
    wt(3);
    chk1(a_oe, 1'b0);
    rdc(`TMCC_OFF_GRA0, 32'hffff, 32'h0abc);
    wr(`TMCC_OFF_IO0, 32'h0c);
    wr(`TMCC_OFF_CNT0, 32'h0def);
    pm0.set_lvl(1'b0);
    pm0.set_lvl(1'b1);
    wt(3);
    rdc(`TMCC_OFF_GRA0, 32'hffff, 32'h0abc);
    wr(`TMCC_OFF_IO0, 32'h07);

    wr(`TMCC_OFF_CNT2, 32'h1234);
    wr(`TMCC_OFF_IO2, 32'h80);
    pm2.set_lvl(1'b1);
    wt(3);
    chk1(b_oe, 1'b0);
    rdc(`TMCC_OFF_GRB2, 32'hffff, 32'h1234);
    rdc(`TMCC_OFF_STAT, 32'h2, 32'h2);
    wr(`TMCC_OFF_IO2, 32'h90);
    wr(`TMCC_OFF_CNT2, 32'h2222);
    pm2.set_lvl(1'b0);
    wt(3);
    rdc(`TMCC_OFF_GRB2, 32'hffff, 32'h2222);
    wr(`TMCC_OFF_CNT2, 32'h3333);
    pm2.set_lvl(1'b1);
    wt(3);
    rdc(`TMCC_OFF_GRB2, 32'hffff, 32'h2222);
    wr(`TMCC_OFF_IO2, 32'ha0);
    pm2.set_lvl(1'b0);
    wt(3);
    rdc(`TMCC_OFF_GRB2, 32'hffff, 32'h3333);

    // Channel 2 as compare: initial level high, driven low at the match.
    wr(`TMCC_OFF_IO2, 32'h50);
    wr(`TMCC_OFF_GRB2, 32'h10);
    wr(`TMCC_OFF_CNT2, 32'h0c);
    wt(3);
    chk1(b_oe, 1'b1);
    chk1(b_o, 1'b1);
    wr(`TMCC_OFF_CTRL, 32'h04);
    wt(8);
    wr(`TMCC_OFF_CTRL, 32'h0);
    chk1(b_o, 1'b0);

    wr(`TMCC_OFF_STAT, 32'hff);
    wr(`TMCC_OFF_TIER0, 32'h10);
    wr(`TMCC_OFF_MASK, 32'h04);
    wr(`TMCC_OFF_GRA0, 32'h10);
    wr(`TMCC_OFF_CNT0, 32'hfffe);
    wr(`TMCC_OFF_CTRL, 32'h1);
    wt(4);
    wr(`TMCC_OFF_CTRL, 32'h0);
    chk1(ovf[0], 1'b1);
    chk1(irq, 1'b1);
    wr(`TMCC_OFF_MASK, 32'h0);
    chk1(irq, 1'b0);
    wr(`TMCC_OFF_STAT, 32'h04);
    chk1(ovf[0], 1'b0);
    wr(`TMCC_OFF_TIER1, 32'h20);
    wr(`TMCC_OFF_CNT1, 32'h1);
    wr(`TMCC_OFF_CTRL, 32'h12);
    wt(4);
    wr(`TMCC_OFF_CTRL, 32'h0);
    chk({29'h0, unf}, 32'h2);

    wr(`TMCC_OFF_STAT, 32'hff);
    wr(`TMCC_OFF_GRA0, 32'hffff);
    wr(`TMCC_OFF_CNT0, 32'hfffd);
    wr(`TMCC_OFF_CTRL, 32'h41);
    wt(6);
    wr(`TMCC_OFF_CTRL, 32'h0);
    rdc(`TMCC_OFF_STAT, 32'h04, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
